// ---- bench/tmcpw_timers_test.sv ----
// Purpose: self-checking bench of the timer set
// Assumes: main and instruction ticks held high, sub ticks off outside the watchdog test; inputs change at the falling edge
// Notes: register images are kept as ints in a model and compared on every read
`timescale 1ns/1ps
`default_nettype none
module tmcpw_timers_test import tmcpw_pkg::*;;
	logic              sys_clk = 0;
	logic              reset_n = 0;
	tmcpw_bus_s        bus     = '0;
	tmcpw_clk_s        ck      = 3'b011;
	tmcpw_pulse_ctrl_s pc      = '0;
	logic              ir_on = 0, mod_on = 0, lo_only = 0, e0 = 0, e1 = 0, tpin = 0;
	logic              ena = 0, dis = 0, ret = 0, tkn = 0, twr = 0, wclr = 0, gm = 0;
	logic [7:0]        twd = '0, rd, ev, pend, tcnt;
	logic [3:0]        pchg = '0;
	logic              wout, sink, gon, wake, wdto;
	int                err_total = 0, n_tests = 0, cyc = 0;
	int                mdl [32] = '{default: 0};

	tmcpw_timers dut (.sys_clk(sys_clk), .reset_n(reset_n), .ctl_bus(bus), .reg_rdata_q(rd),
		.clk_ticks(ck), .pulse_ctrl(pc), .ir_pwm_function_on(ir_on), .carrier_modulate_on(mod_on),
		.low_only_pulse(lo_only), .irq_disable_instr(dis), .irq_enable_instr(ena),
		.irq_return_instr(ret), .irq_taken(tkn), .ext_irq_pin_zero(e0), .ext_irq_pin_one(e1),
		.tick_pin(tpin), .tick_wr(twr), .tick_wdata(twd), .watchdog_clear(wclr), .pin_change(pchg),
		.waveform_out_pin(wout), .output_sink_select(sink), .irq_events_q(ev), .irq_pending_q(pend),
		.irq_global_on_q(gon), .wake_request_q(wake), .tick_count_q(tcnt), .wdt_timeout_q(wdto));

	always #4 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic pg, input logic [3:0] a, input logic [7:0] d);
		@(negedge sys_clk) bus = '{pg, 1'b1, a, d};
		@(negedge sys_clk) bus.wr = 1'b0;
		if ({pg, a} inside {[11:15], [22:25]})
			mdl[{pg, a}] = d & (({pg, a} == 22) ? 8'h8F : ({pg, a} == 24) ? 8'h0F : 8'hFF);
	endtask : wr

	task automatic rd_chk(input logic pg, input logic [3:0] a);
		logic [7:0] e;
		@(negedge sys_clk) bus = '{pg, 1'b0, a, 8'h00};
		@(negedge sys_clk) e = 8'(mdl[{pg, a}]);
		if ({pg, a} == 5'h17)
			e[6] = gm;
		chk(rd, e);
	endtask : rd_chk

	// counts cycles with the chosen flag high; pin change pulses last one cycle
	task automatic watch(input int b, input int n, output int hits);
		hits = 0;
		repeat (n) begin
			@(negedge sys_clk);
			pchg = '0;
			hits += (b == 8) ? int'(wake === 1'b1) : int'(ev[b] === 1'b1);
		end
	endtask : watch

	task automatic period(input int b, output int p);
		p = 0;
		while (ev[b] !== 1'b1 && p < 3000) begin @(negedge sys_clk); p++; end
		p = 0;
		do begin @(negedge sys_clk); p++; end while (ev[b] !== 1'b1 && p < 3000);
	endtask : period

	task automatic run_len(input logic lvl, output int p);
		p = 0;
		while (wout === lvl && p < 3000) begin @(negedge sys_clk); p++; end
		while (wout !== lvl && p < 6000) begin @(negedge sys_clk); p++; end
		p = 0;
		while (wout === lvl && p < 3000) begin @(negedge sys_clk); p++; end
	endtask : run_len

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	initial begin
		static int adr [11] = '{11, 12, 13, 14, 15, 22, 23, 24, 25, 0, 26};
		static logic [7:0] tv [3] = '{8'h00, 8'h08, 8'h0A};
		static int sh [3] = '{0, 1, 3};
		int p, r, n, h, hp, lp;
		logic [7:0] t0;
		void'($urandom(33));
		mdl[23] = 8'hBF;
		repeat (8) @(negedge sys_clk);
		reset_n = 1;
		foreach (adr[i]) rd_chk(adr[i][4], adr[i][3:0]);
		for (int k = 0; k < 2; k++) begin
			foreach (adr[i]) wr(adr[i][4], adr[i][3:0], k ? 8'hFF : 8'($urandom));
			foreach (adr[i]) rd_chk(adr[i][4], adr[i][3:0]);
		end
		$display("registers done");
		for (int k = 0; k < 4; k++) begin
			@(negedge sys_clk) {ena, tkn, ret, dis} = 4'b1000 >> k;
			@(negedge sys_clk) {ena, tkn, ret, dis} = 4'h0;
			gm = ~k[0];
			rd_chk(1'b1, 4'h7);
			chk({7'h00, gon}, {7'h00, gm});
		end
		$display("global enable done");
		wr(1'b1, 4'h6, 8'h00);
		for (int k = 0; k < 8; k++) begin
			if (k == 4)
				wr(1'b1, 4'h6, 8'h8F);
			@(negedge sys_clk) pchg = 4'h1 << k[1:0];
			watch(8, 4, h);
			chk(8'(h), {7'h00, k < 4});
		end
		chk({7'h00, sink}, 8'h01);
		$display("wake done");
		for (int s = 0; s < 2; s++) begin
			wr(1'b1, 4'h7, {s[0], 7'h00});
			@(negedge sys_clk) e0 = 1'b1;
			watch(1, 4, h);
			chk(8'(h), {7'h00, s == 0});
			@(negedge sys_clk) e0 = 1'b0;
			watch(1, 4, h);
			chk(8'(h), {7'h00, s == 1});
		end
		$display("edge select done");
		@(negedge sys_clk) {twr, wclr, twd} = {2'b11, 8'($urandom)};
		@(negedge sys_clk) {twr, wclr} = 2'b00;
		foreach (tv[i]) begin
			wr(1'b1, 4'h7, tv[i]);
			@(negedge sys_clk) t0 = tcnt;
			repeat (64) @(negedge sys_clk);
			chk(tcnt - t0, 8'(64 >> sh[i]));
		end
		for (int s = 0; s < 2; s++) begin
			wr(1'b1, 4'h7, {3'b001, s[0], 4'h0});
			@(negedge sys_clk) t0 = tcnt;
			// pin period of four cycles, longer than the one-cycle instruction clock
			for (int j = 0; j < 64; j++) @(negedge sys_clk) tpin = j[1];
			chk(tcnt - t0, 8'h10);
		end
		$display("tick counter done");
		wr(1'b1, 4'h8, 8'h08);
		@(negedge sys_clk) {ck.sub_tick, wclr} = 2'b11;
		@(negedge sys_clk) wclr = 1'b0;
		p = 0;
		do begin @(negedge sys_clk); p++; end while (wdto !== 1'b1 && p < 3000);
		ck.sub_tick = 1'b0;
		// 256 counts at 1:2 of the sub rate: 512 sub ticks
		chk(8'(p >> 8), 8'h02);
		chk(8'(p), 8'h00);
		$display("watchdog done");
		wr(1'b0, 4'hF, 8'h08);
		for (int i = 0; i < 2; i++) begin
			p = $urandom % 8;
			r = $urandom % 3;
			wr(1'b0, 4'(11 + i), 8'(p));
			wr(1'b1, 4'h9, i ? {1'b1, 3'(r), 4'h0} : {4'h0, 1'b1, 3'(r)});
			period(3 + i, n);
			period(3 + i, n);
			chk(8'(n), 8'((p + 1) << (r + 1)));
			chk(pend, ev & 8'(mdl[15]));
		end
		$display("counters done");
		hp = $urandom % 8;
		lp = $urandom % 8;
		r = $urandom % 3;
		wr(1'b0, 4'hD, 8'(hp));
		wr(1'b0, 4'hE, 8'(lp));
		@(negedge sys_clk) begin
			pc = '{1'b1, 3'(r), 1'b1, 3'(r + 1)};
			ir_on = 1'b1;
		end
		run_len(1'b0, n);
		chk(8'(n), 8'((lp + 1) << (r + 1)));
		run_len(1'b1, n);
		chk(8'(n), 8'((hp + 1) << (r + 2)));
		@(negedge sys_clk) lo_only = 1'b1;
		run_len(1'b0, n);
		chk(8'(n), 8'((lp + 1) << (r + 1)));
		run_len(1'b1, n);
		chk(8'(n), 8'((lp + 1) << (r + 1)));
		$display("waveform done");
		tally_and_finish();
	end
endmodule : tmcpw_timers_test
`default_nettype wire

// ---- rtl/tmcpw_down_timer.sv ----
// Purpose: 8-bit auto-reload down counter behind an 8-bit prescaler
// Assumes: src_tick is a one-cycle enable from the selected oscillator
// Notes: underflow after preset+1 prescaled ticks, reload in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tmcpw_down_timer
	import tmcpw_pkg::*;
(
	input  wire logic       sys_clk,     // system clock
	input  wire logic       reset_n,     // async reset, active low
	input  wire logic       src_tick,    // source clock enable
	input  wire logic       restart,     // hold at preset, clear prescaler
	input  wire logic [2:0] ratio,       // prescale select
	input  wire logic [7:0] preset,      // reload value
	output logic            underflow_q, // one-cycle underflow pulse
	output logic [7:0]      count_q      // current count
);
	logic [7:0] pre_q;
	logic [7:0] pre_d;
	logic [7:0] count_d;
	logic       uf_d;
	logic       step;

	always_comb begin
		step    = src_tick && ((pre_q & tmcpw_scale_mask(ratio)) == tmcpw_scale_mask(ratio));
		pre_d   = pre_q;
		count_d = count_q;
		uf_d    = 1'b0;
		if (restart) begin
			pre_d   = 8'h00;
			count_d = preset;
		end else begin
			if (src_tick)
				pre_d = pre_q + 8'h01;
			if (step) begin
				if (count_q == 8'h00) begin
					count_d = preset;
					uf_d    = 1'b1;
				end else begin
					count_d = count_q - 8'h01;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_q       <= 8'h00;
			count_q     <= 8'h00;
			underflow_q <= 1'b0;
		end else begin
			pre_q       <= pre_d;
			count_q     <= count_d;
			underflow_q <= uf_d;
		end
	end

	reload_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(step && !restart && count_q == 8'h00) |=> (underflow_q && count_q == $past(preset)))
		else $error("down timer did not reload on underflow");

endmodule : tmcpw_down_timer
`default_nettype wire

// ---- rtl/tmcpw_pkg.sv ----
// Purpose: constants, types and helpers of the timer set
// Assumes: one sys_clk at 125 MHz; oscillator and cycle ticks arrive as one-cycle enables
// Notes: registers sit behind the paged control-register port of the core
package tmcpw_pkg;

	// register offsets, page 0
	localparam logic [3:0] TMCPW_OFF_C1_PRESET = 4'hB;
	localparam logic [3:0] TMCPW_OFF_C2_PRESET = 4'hC;
	localparam logic [3:0] TMCPW_OFF_HI_PRESET = 4'hD;
	localparam logic [3:0] TMCPW_OFF_LO_PRESET = 4'hE;
	localparam logic [3:0] TMCPW_OFF_IRQ_MASK  = 4'hF;
	// register offsets, page 1
	localparam logic [3:0] TMCPW_OFF_WAKE      = 4'h6;
	localparam logic [3:0] TMCPW_OFF_TICK_CTRL = 4'h7;
	localparam logic [3:0] TMCPW_OFF_WDT_CTRL  = 4'h8;
	localparam logic [3:0] TMCPW_OFF_C12_CTRL  = 4'h9;

	// reset values
	localparam logic [7:0] TMCPW_RST_WAKE      = 8'h00;
	localparam logic [7:0] TMCPW_RST_TICK_CTRL = 8'hBF;
	localparam logic [7:0] TMCPW_RST_WDT_CTRL  = 8'h00;
	localparam logic [7:0] TMCPW_RST_C12_CTRL  = 8'h00;
	localparam logic [7:0] TMCPW_RST_PRESET    = 8'h00;
	localparam logic [7:0] TMCPW_RST_IRQ_MASK  = 8'h00;

	// writable bit masks
	localparam logic [7:0] TMCPW_WMASK_WAKE    = 8'h8F;
	localparam logic [7:0] TMCPW_WMASK_WDT     = 8'h0F;

	// field positions
	localparam int TMCPW_BIT_SINK      = 7;
	localparam int TMCPW_BIT_INT_EDGE  = 7;
	localparam int TMCPW_BIT_GIE       = 6;
	localparam int TMCPW_BIT_TSRC      = 5;
	localparam int TMCPW_BIT_TEDGE     = 4;
	localparam int TMCPW_BIT_TICK_PRESCALE_ON      = 3;
	localparam int TMCPW_BIT_WDT_ON    = 3;
	localparam int TMCPW_BIT_C2_SEL    = 7;
	localparam int TMCPW_BIT_C1_SEL    = 3;

	// event and mask bit order
	localparam int TMCPW_EV_TICK = 0;
	localparam int TMCPW_EV_EXT0 = 1;
	localparam int TMCPW_EV_EXT1 = 2;
	localparam int TMCPW_EV_C1   = 3;
	localparam int TMCPW_EV_C2   = 4;
	localparam int TMCPW_EV_HI   = 5;
	localparam int TMCPW_EV_LO   = 6;
	localparam int TMCPW_EV_PIN  = 7;

	localparam logic [7:0] TMCPW_CNT_TOP = 8'hFF;

	typedef struct packed {
		logic       page;  // page select bit of the core
		logic       wr;    // write strobe
		logic [3:0] addr;  // register offset
		logic [7:0] wdata; // write data
	} tmcpw_bus_s;

	typedef struct packed {
		logic sub_tick;   // sub-oscillator tick
		logic main_tick;  // main-oscillator tick
		logic instr_tick; // instruction cycle tick
	} tmcpw_clk_s;

	typedef struct packed {
		logic       low_pulse_clk_select;
		logic [2:0] low_ratio;
		logic       high_pulse_clk_select;
		logic [2:0] high_ratio;
	} tmcpw_pulse_ctrl_s;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_HIGH = 2'b01,
		PH_LOW  = 2'b10
	} tmcpw_phase_e;

	// prescaler match mask: field 0..7 selects 1:2 .. 1:256
	function automatic logic [7:0] tmcpw_scale_mask(input logic [2:0] ratio);
		tmcpw_scale_mask = 8'((9'h002 << ratio) - 9'h001);
	endfunction : tmcpw_scale_mask

endpackage : tmcpw_pkg

// ---- rtl/tmcpw_timers.sv ----
// Purpose: counters, pulse width timers, carrier, tick counter, watchdog and their control registers
// Assumes: all pins and ticks synchronous to sys_clk; registers reached over the paged core port
// Notes: read data is registered, one cycle after the address; the status flags live outside
`timescale 1ns/1ps
`default_nettype none
module tmcpw_timers
	import tmcpw_pkg::*;
(
	input  wire logic              sys_clk,              // system clock
	input  wire logic              reset_n,              // async reset, active low
	input  wire tmcpw_bus_s        ctl_bus,              // core register port
	output logic [7:0]             reg_rdata_q,          // registered read data
	input  wire tmcpw_clk_s        clk_ticks,            // oscillator and cycle enables
	input  wire tmcpw_pulse_ctrl_s pulse_ctrl,           // pulse timer clock and prescale
	input  wire logic              ir_pwm_function_on,   // waveform generator enable
	input  wire logic              carrier_modulate_on,  // modulate low phases
	input  wire logic              low_only_pulse,       // low timer times both phases
	input  wire logic              irq_disable_instr,    // disable instruction executed
	input  wire logic              irq_enable_instr,     // enable instruction executed
	input  wire logic              irq_return_instr,     // return-from-interrupt executed
	input  wire logic              irq_taken,            // hardware interrupt accepted
	input  wire logic              ext_irq_pin_zero,     // external interrupt zero pin
	input  wire logic              ext_irq_pin_one,      // external interrupt one pin
	input  wire logic              tick_pin,             // external tick counter pin
	input  wire logic              tick_wr,              // core writes the tick counter
	input  wire logic [7:0]        tick_wdata,           // value written to tick counter
	input  wire logic              watchdog_clear,       // watchdog clear or sleep instruction
	input  wire logic [3:0]        pin_change,           // change pulses p8h,p8l,p6h,p6l
	output logic                   waveform_out_pin,     // PWM / IR waveform
	output logic                   output_sink_select,   // waveform pin sink strength
	output logic [7:0]             irq_events_q,         // one-cycle interrupt events
	output logic [7:0]             irq_pending_q,        // events passed by the mask
	output logic                   irq_global_on_q,      // global interrupt enable
	output logic                   wake_request_q,       // enabled pin-change wake-up
	output logic [7:0]             tick_count_q,         // tick counter value
	output logic                   wdt_timeout_q         // watchdog timeout pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// control registers
	logic [7:0] wake_q, wake_d, tctl_q, tctl_d, wctl_q, wctl_d, c12_q, c12_d;
	logic [7:0] c1_pre_q, c1_pre_d, c2_pre_q, c2_pre_d, hi_pre_q, hi_pre_d;
	logic [7:0] lo_pre_q, lo_pre_d, imr_q, imr_d, rdata_d;
	logic       gie_d;

	function automatic logic hit(input tmcpw_bus_s b, input logic pg, input logic [3:0] off);
		hit = b.page == pg && b.addr == off;
	endfunction : hit

	always_comb begin
		wake_d   = wake_q;
		tctl_d   = tctl_q;
		wctl_d   = wctl_q;
		c12_d    = c12_q;
		c1_pre_d = c1_pre_q;
		c2_pre_d = c2_pre_q;
		hi_pre_d = hi_pre_q;
		lo_pre_d = lo_pre_q;
		imr_d    = imr_q;
		if (ctl_bus.wr) begin
			if (hit(ctl_bus, 1'b1, TMCPW_OFF_WAKE))      wake_d = ctl_bus.wdata & TMCPW_WMASK_WAKE;
			if (hit(ctl_bus, 1'b1, TMCPW_OFF_TICK_CTRL)) tctl_d = ctl_bus.wdata;
			if (hit(ctl_bus, 1'b1, TMCPW_OFF_WDT_CTRL))  wctl_d = ctl_bus.wdata & TMCPW_WMASK_WDT;
			if (hit(ctl_bus, 1'b1, TMCPW_OFF_C12_CTRL))  c12_d = ctl_bus.wdata;
			if (hit(ctl_bus, 1'b0, TMCPW_OFF_C1_PRESET)) c1_pre_d = ctl_bus.wdata;
			if (hit(ctl_bus, 1'b0, TMCPW_OFF_C2_PRESET)) c2_pre_d = ctl_bus.wdata;
			if (hit(ctl_bus, 1'b0, TMCPW_OFF_HI_PRESET)) hi_pre_d = ctl_bus.wdata;
			if (hit(ctl_bus, 1'b0, TMCPW_OFF_LO_PRESET)) lo_pre_d = ctl_bus.wdata;
			if (hit(ctl_bus, 1'b0, TMCPW_OFF_IRQ_MASK))  imr_d = ctl_bus.wdata;
		end
		// disable and hardware interrupt win over enable in the same cycle
		gie_d = irq_global_on_q;
		if (irq_enable_instr || irq_return_instr)
			gie_d = 1'b1;
		if (irq_disable_instr || irq_taken)
			gie_d = 1'b0;
		rdata_d = 8'h00;
		if (hit(ctl_bus, 1'b1, TMCPW_OFF_WAKE))      rdata_d = wake_q;
		if (hit(ctl_bus, 1'b1, TMCPW_OFF_TICK_CTRL)) begin
			rdata_d                 = tctl_q;
			rdata_d[TMCPW_BIT_GIE]  = irq_global_on_q;
		end
		if (hit(ctl_bus, 1'b1, TMCPW_OFF_WDT_CTRL))  rdata_d = wctl_q;
		if (hit(ctl_bus, 1'b1, TMCPW_OFF_C12_CTRL))  rdata_d = c12_q;
		if (hit(ctl_bus, 1'b0, TMCPW_OFF_C1_PRESET)) rdata_d = c1_pre_q;
		if (hit(ctl_bus, 1'b0, TMCPW_OFF_C2_PRESET)) rdata_d = c2_pre_q;
		if (hit(ctl_bus, 1'b0, TMCPW_OFF_HI_PRESET)) rdata_d = hi_pre_q;
		if (hit(ctl_bus, 1'b0, TMCPW_OFF_LO_PRESET)) rdata_d = lo_pre_q;
		if (hit(ctl_bus, 1'b0, TMCPW_OFF_IRQ_MASK))  rdata_d = imr_q;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_q          <= TMCPW_RST_WAKE;
			tctl_q          <= TMCPW_RST_TICK_CTRL;
			wctl_q          <= TMCPW_RST_WDT_CTRL;
			c12_q           <= TMCPW_RST_C12_CTRL;
			c1_pre_q        <= TMCPW_RST_PRESET;
			c2_pre_q        <= TMCPW_RST_PRESET;
			hi_pre_q        <= TMCPW_RST_PRESET;
			lo_pre_q        <= TMCPW_RST_PRESET;
			imr_q           <= TMCPW_RST_IRQ_MASK;
			irq_global_on_q <= 1'b0;
			reg_rdata_q     <= 8'h00;
		end else begin
			wake_q          <= wake_d;
			tctl_q          <= tctl_d;
			wctl_q          <= wctl_d;
			c12_q           <= c12_d;
			c1_pre_q        <= c1_pre_d;
			c2_pre_q        <= c2_pre_d;
			hi_pre_q        <= hi_pre_d;
			lo_pre_q        <= lo_pre_d;
			imr_q           <= imr_d;
			irq_global_on_q <= gie_d;
			reg_rdata_q     <= rdata_d;
		end
	end

	assign output_sink_select = wake_q[TMCPW_BIT_SINK];

	// four down timers
	logic         c1_uf, c2_uf, hi_uf, lo_uf, hi_restart, lo_restart;
	tmcpw_phase_e phase_q, phase_d;

	tmcpw_down_timer u_cnt_one (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.src_tick    (c12_q[TMCPW_BIT_C1_SEL] ? clk_ticks.main_tick : clk_ticks.sub_tick),
		.restart     (1'b0),
		.ratio       (c12_q[2:0]),
		.preset      (c1_pre_q),
		.underflow_q (c1_uf),
		.count_q     ()
	);

	tmcpw_down_timer u_cnt_two (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.src_tick    (c12_q[TMCPW_BIT_C2_SEL] ? clk_ticks.main_tick : clk_ticks.sub_tick),
		.restart     (1'b0),
		.ratio       (c12_q[6:4]),
		.preset      (c2_pre_q),
		.underflow_q (c2_uf),
		.count_q     ()
	);

	tmcpw_down_timer u_high_pulse (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.src_tick    (pulse_ctrl.high_pulse_clk_select ? clk_ticks.main_tick : clk_ticks.sub_tick),
		.restart     (hi_restart),
		.ratio       (pulse_ctrl.high_ratio),
		.preset      (hi_pre_q),
		.underflow_q (hi_uf),
		.count_q     ()
	);

	tmcpw_down_timer u_low_pulse (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.src_tick    (pulse_ctrl.low_pulse_clk_select ? clk_ticks.main_tick : clk_ticks.sub_tick),
		.restart     (lo_restart),
		.ratio       (pulse_ctrl.low_ratio),
		.preset      (lo_pre_q),
		.underflow_q (lo_uf),
		.count_q     ()
	);

	// waveform phases and carrier
	logic carrier_q, carrier_d, wave_d;

	always_comb begin
		carrier_d  = c2_uf ? !carrier_q : carrier_q;
		phase_d    = phase_q;
		unique case (phase_q)
			PH_IDLE: if (ir_pwm_function_on) phase_d = PH_HIGH;
			PH_HIGH: begin
				if (!ir_pwm_function_on)
					phase_d = PH_IDLE;
				else if (low_only_pulse ? lo_uf : hi_uf)
					phase_d = PH_LOW;
			end
			PH_LOW: begin
				if (!ir_pwm_function_on)
					phase_d = PH_IDLE;
				else if (lo_uf)
					phase_d = PH_HIGH;
			end
			default: phase_d = PH_IDLE;
		endcase
		// timers count from the boundary edge itself, so the registered underflow adds no cycle
		hi_restart = phase_d != PH_HIGH || low_only_pulse;
		lo_restart = phase_d == PH_IDLE || (phase_d == PH_HIGH && !low_only_pulse);
		wave_d = phase_d == PH_HIGH || (phase_d == PH_LOW && carrier_modulate_on && carrier_d);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q          <= PH_IDLE;
			carrier_q        <= 1'b0;
			waveform_out_pin <= 1'b0;
		end else begin
			phase_q          <= phase_d;
			carrier_q        <= carrier_d;
			waveform_out_pin <= wave_d;
		end
	end

	// tick counter, watchdog, external pins and events
	logic [7:0] tpre_q, tpre_d, tick_d, wpre_q, wpre_d, wcnt_q, wcnt_d, ev_d;
	logic       tpin_q, ext_irq_pin_zero_q, int1_q, wdt_d, wake_d2;
	logic       tsrc, tstep, wstep, tedge, ext_irq_pin_zero_ev;

	always_comb begin
		tedge = tctl_q[TMCPW_BIT_TEDGE] ? (tpin_q && !tick_pin) : (!tpin_q && tick_pin);
		tsrc  = tctl_q[TMCPW_BIT_TSRC] ? tedge : clk_ticks.instr_tick;
		tstep = tctl_q[TMCPW_BIT_TICK_PRESCALE_ON] ?
			(tsrc && ((tpre_q & tmcpw_scale_mask(tctl_q[2:0])) == tmcpw_scale_mask(tctl_q[2:0]))) : tsrc;
		tpre_d = tsrc ? tpre_q + 8'h01 : tpre_q;
		tick_d = tstep ? tick_count_q + 8'h01 : tick_count_q;
		if (tick_wr) begin
			tpre_d = 8'h00;
			tick_d = tick_wdata;
		end
		// prescaler counts sub ticks, so the rate is the selected ratio of Fs, 1:2 at field 0
		wstep  = clk_ticks.sub_tick && ((wpre_q & tmcpw_scale_mask(wctl_q[2:0])) ==
			tmcpw_scale_mask(wctl_q[2:0]));
		wpre_d = clk_ticks.sub_tick ? wpre_q + 8'h01 : wpre_q;
		wcnt_d = wstep ? wcnt_q + 8'h01 : wcnt_q;
		wdt_d  = wctl_q[TMCPW_BIT_WDT_ON] && wstep && wcnt_q == TMCPW_CNT_TOP;
		if (!wctl_q[TMCPW_BIT_WDT_ON] || watchdog_clear) begin
			wpre_d = 8'h00;
			wcnt_d = 8'h00;
		end
		ext_irq_pin_zero_ev = tctl_q[TMCPW_BIT_INT_EDGE] ? (ext_irq_pin_zero_q && !ext_irq_pin_zero) : (!ext_irq_pin_zero_q && ext_irq_pin_zero);
		ev_d                = 8'h00;
		ev_d[TMCPW_EV_TICK] = tstep && !tick_wr && tick_count_q == TMCPW_CNT_TOP;
		ev_d[TMCPW_EV_EXT0] = ext_irq_pin_zero_ev;
		ev_d[TMCPW_EV_EXT1] = int1_q && !ext_irq_pin_one;
		ev_d[TMCPW_EV_C1]   = c1_uf;
		ev_d[TMCPW_EV_C2]   = c2_uf;
		ev_d[TMCPW_EV_HI]   = hi_uf;
		ev_d[TMCPW_EV_LO]   = lo_uf;
		ev_d[TMCPW_EV_PIN]  = |pin_change;
		wake_d2 = |(pin_change & ~wake_q[3:0]);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tpre_q         <= 8'h00;
			tick_count_q   <= 8'h00;
			wpre_q         <= 8'h00;
			wcnt_q         <= 8'h00;
			wdt_timeout_q  <= 1'b0;
			tpin_q         <= 1'b0;
			ext_irq_pin_zero_q         <= 1'b0;
			int1_q         <= 1'b0;
			irq_events_q   <= 8'h00;
			irq_pending_q  <= 8'h00;
			wake_request_q <= 1'b0;
		end else begin
			tpre_q         <= tpre_d;
			tick_count_q   <= tick_d;
			wpre_q         <= wpre_d;
			wcnt_q         <= wcnt_d;
			wdt_timeout_q  <= wdt_d;
			tpin_q         <= tick_pin;
			ext_irq_pin_zero_q         <= ext_irq_pin_zero;
			int1_q         <= ext_irq_pin_one;
			irq_events_q   <= ev_d;
			irq_pending_q  <= ev_d & imr_q;
			wake_request_q <= wake_d2;
		end
	end

	gie_clear_a: assert property ((irq_disable_instr || irq_taken) |=> !irq_global_on_q)
		else $error("global enable not cleared");
	gie_set_a: assert property ((irq_enable_instr && !irq_disable_instr && !irq_taken) |=> irq_global_on_q)
		else $error("global enable not set");
	wake_gate_a: assert property (wake_request_q |-> |($past(pin_change) & ~$past(wake_q[3:0])))
		else $error("wake-up from a disabled nibble");
	mask_gate_a: assert property (irq_pending_q[TMCPW_EV_C1] |-> ($past(imr_q[TMCPW_EV_C1]) && irq_events_q[TMCPW_EV_C1]))
		else $error("masked counter one event passed");
	carrier_flip_a: assert property (c2_uf |=> carrier_q != $past(carrier_q))
		else $error("carrier did not toggle");
	high_out_a: assert property (phase_q == PH_HIGH |-> waveform_out_pin)
		else $error("output low in high phase");
	high_end_a: assert property ((phase_q == PH_HIGH && ir_pwm_function_on && !low_only_pulse && hi_uf)
		|=> phase_q == PH_LOW)
		else $error("high phase did not end on underflow");
	low_end_a: assert property ((phase_q == PH_LOW && ir_pwm_function_on && lo_uf) |=> phase_q == PH_HIGH)
		else $error("low phase did not end on underflow");
	low_plain_a: assert property ((phase_q == PH_LOW && !carrier_modulate_on) |-> !waveform_out_pin)
		else $error("unmodulated low phase not low");
	tick_wrap_a: assert property ((tstep && !tick_wr && tick_count_q == TMCPW_CNT_TOP)
		|=> (tick_count_q == 8'h00 && irq_events_q[TMCPW_EV_TICK]))
		else $error("tick overflow missed");
	ext0_edge_a: assert property ((!tctl_q[TMCPW_BIT_INT_EDGE] && !ext_irq_pin_zero_q && ext_irq_pin_zero)
		|=> irq_events_q[TMCPW_EV_EXT0])
		else $error("rising edge on ext zero missed");
	wdt_off_a: assert property (!$past(wctl_q[TMCPW_BIT_WDT_ON]) |-> !wdt_timeout_q)
		else $error("watchdog fired while off");

endmodule : tmcpw_timers
`default_nettype wire
